// File: fpsg_defs.vh
/*
 Constants for the flash protection and security gate: register offsets,
 protection level encodings, command codes and the security key.
 Assumes inclusion by bare name from the design files.
*/
`ifndef FPSG_DEFS_VH
`define FPSG_DEFS_VH

// Register byte offsets
`define FPSG_OFS_CTRL     8'h00
`define FPSG_OFS_STATUS   8'h04
`define FPSG_OFS_LATCH    8'h08
`define FPSG_OFS_ROWSEL   8'h0C
`define FPSG_OFS_LEVEL    8'h10
`define FPSG_OFS_CMD      8'h14

// Protection levels, two bits per row
`define FPSG_LVL_OPEN     2'h0
`define FPSG_LVL_NOEXTRD  2'h1
`define FPSG_LVL_NOEXTWR  2'h2
`define FPSG_LVL_FULL     2'h3

// Command codes written to the command register
`define FPSG_CMD_ERASE    8'hE1
`define FPSG_CMD_RESET    8'hA5

// Security key; arbitrary value
`define FPSG_KEY          32'h5EC0_A11E

// Field positions
`define FPSG_CTRL_DBG     0
`define FPSG_CTRL_TST     1
`define FPSG_ST_SECURE    0
`define FPSG_ST_LATCHWR   1
`define FPSG_ST_DBG       2
`define FPSG_ST_TST       3
`define FPSG_ST_ERASED    4

`endif

// File: fpsg_row_table.v
/*
 Per-row protection level store. A level may be written only while the
 row is unprogrammed since the last bulk erase or reset; bulk erase clears all.
 Assumes one clock and an active low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fpsg_defs.vh"

module fpsg_row_table #(
  parameter ROWS  = 64,
  parameter AW    = 6
) (
  input  wire          sys_clk,
  input  wire          rst_b,
  input  wire          bulk_erase,
  input  wire          set_level,
  input  wire [AW-1:0] set_row,
  input  wire [1:0]    set_value,
  input  wire [AW-1:0] rd_row,
  output reg  [1:0]    rd_level,
  output reg           set_refused
);

  reg [1:0] level [0:ROWS-1];
  reg       frozen [0:ROWS-1];

  genvar gi;
  generate
    for (gi = 0; gi < ROWS; gi = gi + 1) begin : g_row
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          level[gi]  <= `FPSG_LVL_OPEN;
          frozen[gi] <= 1'b0;
        end else if (bulk_erase) begin
          // Erase clears even the highest level
          level[gi]  <= `FPSG_LVL_OPEN;
          frozen[gi] <= 1'b0;
        end else if (set_level && (set_row == gi) && !frozen[gi]) begin
          // Level is programmed once per erase cycle
          level[gi]  <= set_value;
          frozen[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_level    <= `FPSG_LVL_OPEN;
      set_refused <= 1'b0;
    end else begin
      rd_level    <= level[rd_row];
      // Held until the next level write so software can read the outcome
      if (set_level)
        set_refused <= !bulk_erase && frozen[set_row];
    end
  end

endmodule // fpsg_row_table

`default_nettype wire

// File: fpsg_gate.v
/*
 Flash protection and security gate: AHB-Lite register slave, write-once
 security latch, debug/test entry control and per-access permission check.
 Assumes a single 40 MHz clock, AHB-Lite master with word transfers, and
 flash access requests held stable until the registered grant answers.
*/
// Our own choices: the AHB-Lite slave port and the placing of the registers.
//
// Contract
// - Each row has own level; bootloader writes allowed
// - Programmed level change refused until bulk erase
// - Highest level rows writable only after erase
// - Internal reads allowed at every level
// - Debug mode ignores read protection
// - Debug mode keeps write protection
// - Latched key blocks debug and test entry
// - Latched key blocks reprogramming through test mode
// - Latched key blocks debug via boundary scan
// - Security latch readable over SWD
// - Security refuses all external flash access
// - Security still allows bootloader non-full row updates
`timescale 1ns/10ps
`default_nettype none
`include "fpsg_defs.vh"

module fpsg_gate #(
  parameter ROWS = 64,
  parameter AW   = 6
) (
  input  wire          sys_clk,
  input  wire          rst_b,
  // AHB-Lite slave
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output wire          hreadyout,
  output wire          hresp,
  output reg  [31:0]   hrdata,
  // Debug/test entry requests from the test controller
  input  wire          dbg_entry_req,
  input  wire          tst_entry_req,
  input  wire          jtag_bscan_active,
  // SWD read port of the security latch
  output reg  [31:0]   swd_latch_data,
  output reg           swd_secure,
  // Flash access request
  input  wire          acc_req,
  input  wire          acc_write,
  input  wire          acc_external,
  input  wire          acc_boot,
  input  wire [AW-1:0] acc_row,
  output reg           acc_done,
  output reg           acc_grant,
  // Mode outputs
  output reg           dbg_mode,
  output reg           tst_mode,
  output reg           part_reset_req
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_LOOK  = 3'b010;
  localparam ST_DONE  = 3'b100;

  // Bus signals
  reg         dp_valid;
  reg         dp_write;
  reg  [7:0]  dp_addr;
  wire        ap_take;
  wire        wr_fire;

  // Control and status
  reg  [31:0] latch_val;
  reg         latch_written;
  reg         secure;
  reg         dbg_allow;
  reg         tst_allow;
  reg  [AW-1:0] row_sel;
  reg         erased_flag;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         next_grant;

  // Row table hookup
  wire        bulk_erase;
  wire        set_level;
  wire [1:0]  row_level;
  wire        set_refused;
  wire        key_match;
  wire        secure_pending;
  wire        dbg_ok;
  wire        tst_ok;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = hsel && hready && htrans[1];
  assign wr_fire   = dp_valid && dp_write;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= ap_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // Commands from software or the programmer
  assign bulk_erase = wr_fire && (dp_addr == `FPSG_OFS_CMD) &&
                      (hwdata[7:0] == `FPSG_CMD_ERASE);
  assign set_level  = wr_fire && (dp_addr == `FPSG_OFS_LEVEL);
  assign key_match  = (latch_val == `FPSG_KEY);
  // Security takes effect only after a part reset
  assign secure_pending = latch_written && key_match;

  fpsg_row_table #(
    .ROWS (ROWS),
    .AW   (AW)
  ) u_rows (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .bulk_erase  (bulk_erase),
    .set_level   (set_level),
    .set_row     (row_sel),
    .set_value   (hwdata[1:0]),
    .rd_row      (acc_row),
    .rd_level    (row_level),
    .set_refused (set_refused)
  );

  // Write-once latch survives the part reset request; only rst_b clears it
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_val     <= 32'h0000_0000;
      latch_written <= 1'b0;
      secure        <= 1'b0;
      row_sel       <= {AW{1'b0}};
      dbg_allow     <= 1'b0;
      tst_allow     <= 1'b0;
      erased_flag   <= 1'b0;
      part_reset_req <= 1'b0;
    end else begin
      part_reset_req <= 1'b0;
      if (wr_fire && (dp_addr == `FPSG_OFS_LATCH) && !latch_written) begin
        latch_val     <= hwdata;
        latch_written <= 1'b1;
      end
      if (wr_fire && (dp_addr == `FPSG_OFS_CMD) &&
          (hwdata[7:0] == `FPSG_CMD_RESET)) begin
        part_reset_req <= 1'b1;
        // A non-key value never arms security
        secure         <= secure_pending;
        dbg_allow      <= 1'b0;
        tst_allow      <= 1'b0;
      end else if (wr_fire && (dp_addr == `FPSG_OFS_CTRL)) begin
        dbg_allow <= hwdata[`FPSG_CTRL_DBG];
        tst_allow <= hwdata[`FPSG_CTRL_TST];
      end
      if (wr_fire && (dp_addr == `FPSG_OFS_ROWSEL))
        row_sel <= hwdata[AW-1:0];
      // Sticky erase indication; a new erase wins over a software clear
      if (bulk_erase)
        erased_flag <= 1'b1;
      else if (wr_fire && (dp_addr == `FPSG_OFS_STATUS) && hwdata[`FPSG_ST_ERASED])
        erased_flag <= 1'b0;
    end
  end

  // Entry is refused once secured, boundary scan or not
  assign dbg_ok = dbg_allow && !secure;
  assign tst_ok = tst_allow && !secure;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dbg_mode <= 1'b0;
      tst_mode <= 1'b0;
    end else begin
      dbg_mode <= (dbg_entry_req || jtag_bscan_active || dbg_mode) && dbg_ok;
      tst_mode <= (tst_entry_req || tst_mode) && tst_ok;
    end
  end

  // Latch kept visible on the SWD side at all times
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      swd_latch_data <= 32'h0000_0000;
      swd_secure     <= 1'b0;
    end else begin
      swd_latch_data <= latch_val;
      swd_secure     <= secure_pending;
    end
  end

  // Access check: one cycle to fetch the row level, one to decide
  always @* begin
    next_state = state;
    next_grant = 1'b0;
    case (state)
      ST_IDLE: begin
        if (acc_req)
          next_state = ST_LOOK;
      end
      ST_LOOK: begin
        next_state = ST_DONE;
        if (!acc_external) begin
          if (!acc_write)
            next_grant = 1'b1;
          else
            // Bootloader updates rows below full level
            next_grant = acc_boot && (row_level != `FPSG_LVL_FULL);
        end else if (secure) begin
          next_grant = 1'b0;
        end else if (!acc_write) begin
          next_grant = dbg_mode || tst_mode ||
                       ((row_level != `FPSG_LVL_NOEXTRD) &&
                        (row_level != `FPSG_LVL_FULL));
        end else begin
          // Write protection holds in every mode
          next_grant = (row_level == `FPSG_LVL_OPEN) ||
                       (row_level == `FPSG_LVL_NOEXTRD);
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      acc_grant <= 1'b0;
      acc_done  <= 1'b0;
    end else begin
      state    <= next_state;
      acc_done <= (state == ST_LOOK);
      if (state == ST_LOOK)
        acc_grant <= next_grant;
      else if (state == ST_IDLE)
        acc_grant <= 1'b0;
    end
  end

  // Read mux
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      case (haddr[7:0])
        `FPSG_OFS_CTRL:   hrdata <= {30'h0000_0000, tst_allow, dbg_allow};
        `FPSG_OFS_STATUS: hrdata <= {27'h0000_000, erased_flag, tst_mode,
                                     dbg_mode, latch_written, secure};
        `FPSG_OFS_LATCH:  hrdata <= latch_val;
        `FPSG_OFS_ROWSEL: hrdata <= {{(32-AW){1'b0}}, row_sel};
        `FPSG_OFS_LEVEL:  hrdata <= {29'h0000_0000, set_refused, row_level};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // fpsg_gate

`default_nettype wire

// File: fpsg_gate_asserts.sv
/* Port assertions for fpsg_gate.
 Bound from the testbench; one clock, async active low reset. */
`timescale 1ns/10ps
`default_nettype none
`include "fpsg_defs.vh"
module fpsg_gate_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [31:0] swd_latch_data,
  input wire logic        swd_secure,
  input wire logic        acc_req,
  input wire logic        acc_write,
  input wire logic        acc_external,
  input wire logic        acc_done,
  input wire logic        acc_grant,
  input wire logic        dbg_mode,
  input wire logic        tst_mode,
  input wire logic        dbg_entry_req,
  input wire logic        jtag_bscan_active,
  input wire logic        part_reset_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Security only bites after a part reset with the key latched
  logic locked;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      locked <= 1'b0;
    else if (part_reset_req && swd_secure)
      locked <= 1'b1;
  end
  sequence s_req; $rose(acc_req); endsequence
  sequence s_ans; ##2 acc_done ##1 !acc_done; endsequence
  sequence s_rd; acc_done && !acc_write; endsequence
  a_answer_time: assert property (s_req |-> s_ans)
    else $error("access answer late");
  a_internal_read: assert property (s_rd and !acc_external |-> acc_grant)
    else $error("internal read refused");
  a_debug_read: assert property (s_rd and acc_external && dbg_mode && !swd_secure
    |-> acc_grant) else $error("debug read refused");
  a_secure_ext: assert property (acc_done && acc_external && locked |-> !acc_grant)
    else $error("external access on secure part");
  a_secure_dbg: assert property (locked |-> !dbg_mode)
    else $error("debug mode on secure part");
  a_secure_tst: assert property (locked |-> !tst_mode)
    else $error("test mode on secure part");
  a_bscan_dbg: assert property (locked && jtag_bscan_active |=> !dbg_mode)
    else $error("debug via scan on secure part");
  a_latch_mirror: assert property (swd_secure |-> swd_latch_data == `FPSG_KEY)
    else $error("secure without key");
  a_dbg_cause: assert property ($rose(dbg_mode) |->
    $past(dbg_entry_req || jtag_bscan_active) && !$past(locked))
    else $error("debug entry without cause");
endmodule // fpsg_gate_asserts
`default_nettype wire

// File: fpsg_prog.sv
/* Requester model: flash accesses and debug/test entry pins.
 Driven by testbench task calls; one clock. */
`timescale 1ns/10ps
`default_nettype none
module fpsg_prog (
  input wire logic  sys_clk,
  input wire logic  acc_done,
  input wire logic  acc_grant,
  output logic       acc_req,
  output logic       acc_write,
  output logic       acc_external,
  output logic       acc_boot,
  output logic [5:0] acc_row,
  output logic       dbg_entry_req,
  output logic       tst_entry_req,
  output logic       jtag_bscan_active
);
  initial begin
    {acc_req, acc_write, acc_external, acc_boot, acc_row} = 10'h000;
    {dbg_entry_req, tst_entry_req, jtag_bscan_active} = 3'h0;
  end
  task access(input logic w, e, b, input logic [5:0] r, output logic g, ok);
    integer i;
    @(posedge sys_clk);
    acc_req <= 1'b1;
    {acc_write, acc_external, acc_boot, acc_row} <= {w, e, b, r};
    ok = 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge sys_clk);
      ok = acc_done === 1'b1;
    end
    g = acc_grant;
    acc_req <= 1'b0;
    // Released row lines toggle so a stale row is never trusted
    acc_row <= ~r;
  endtask
  task modes(input logic d, t, j);
    @(posedge sys_clk);
    {dbg_entry_req, tst_entry_req, jtag_bscan_active} <= {d, t, j};
  endtask
endmodule // fpsg_prog
`default_nettype wire

// File: flash_protection_security_gate_tb.sv
/* Self-checking bench for fpsg_gate.
 AHB-Lite master tasks; fpsg_prog drives the access side. */
`timescale 1ns/10ps
`default_nettype none
`include "fpsg_defs.vh"
module flash_protection_security_gate_tb;
  logic sys_clk = 0, rst_b = 0, hwrite = 0, g, ok;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  wire logic hreadyout, hresp, acc_req, acc_write, acc_external, acc_boot, acc_done;
  wire logic acc_grant, dbg_mode, tst_mode, dbg_entry_req, tst_entry_req, jtag_bscan_active;
  wire logic [31:0] hrdata, swd_latch_data;
  wire logic swd_secure;
  wire logic [5:0] acc_row;
  integer fails = 0, n_tests = 0, seed = 32'hB80C5D8F, k, r;
  fpsg_gate dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dbg_entry_req(dbg_entry_req),
    .tst_entry_req(tst_entry_req), .jtag_bscan_active(jtag_bscan_active),
    .swd_latch_data(swd_latch_data), .swd_secure(swd_secure), .acc_req(acc_req),
    .acc_write(acc_write), .acc_external(acc_external), .acc_boot(acc_boot),
    .acc_row(acc_row), .acc_done(acc_done), .acc_grant(acc_grant), .dbg_mode(dbg_mode),
    .tst_mode(tst_mode), .part_reset_req());
  fpsg_prog u_prog (.sys_clk(sys_clk), .acc_done(acc_done), .acc_grant(acc_grant),
    .acc_req(acc_req), .acc_write(acc_write), .acc_external(acc_external),
    .acc_boot(acc_boot), .acc_row(acc_row), .dbg_entry_req(dbg_entry_req),
    .tst_entry_req(tst_entry_req), .jtag_bscan_active(jtag_bscan_active));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task results;
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task hang(input logic done);
    if (!done) begin
      fails++;
      results;
    end
  endtask
  task rdy;
    integer j;
    ok = 1'b0;
    for (j = 0; j < 20 && !ok; j++) begin
      @(posedge sys_clk);
      ok = hreadyout === 1'b1;
    end
    hang(ok);
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {haddr, htrans, hwrite} <= {24'h0, a, 2'h2, w};
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task rst;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask
  task levels;
    for (k = 0; k < 4; k++) begin
      xfer(1, `FPSG_OFS_ROWSEL, k);
      xfer(1, `FPSG_OFS_LEVEL, k);
    end
  endtask
  function logic fx(input logic [1:0] l, input logic w, e, b, m, s);
    if (!e) fx = w ? (b && l != 2'h3) : 1'b1;
    else if (s) fx = 1'b0;
    else if (w) fx = l < 2'h2;
    else fx = m || (l != 2'h1 && l != 2'h3);
  endfunction
  // Row n holds level n, so the row number also names the level
  task rnd(input logic m, s);
    repeat (16) begin
      r = $random(seed);
      u_prog.access(r[2], r[3], r[4], {4'h0, r[1:0]}, g, ok);
      hang(ok);
      chk(g, fx(r[1:0], r[2], r[3], r[4], m, s));
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    xfer(1, `FPSG_OFS_CMD, `FPSG_CMD_ERASE);
    levels;
    xfer(0, `FPSG_OFS_LEVEL, 0);
    chk(rd[2], 1'b0);
    xfer(1, `FPSG_OFS_ROWSEL, 0);
    xfer(1, `FPSG_OFS_LEVEL, `FPSG_LVL_FULL);
    xfer(0, `FPSG_OFS_LEVEL, 0);
    chk(rd[2], 1'b1);
    xfer(0, 8'h40, 0);
    chk(rd, 0);
    rnd(0, 0);
    xfer(1, `FPSG_OFS_CMD, `FPSG_CMD_ERASE);
    u_prog.access(1, 0, 1, 6'h03, g, ok);
    chk(g, 1'b1);
    levels;
    $display("test 1 done");
    xfer(1, `FPSG_OFS_CTRL, 3);
    u_prog.modes(1, 1, 0);
    repeat (3) @(posedge sys_clk);
    chk({dbg_mode, tst_mode}, 2'h3);
    rnd(1, 0);
    $display("test 2 done");
    xfer(1, `FPSG_OFS_LATCH, `FPSG_KEY ^ 32'h1);
    xfer(1, `FPSG_OFS_CMD, `FPSG_CMD_RESET);
    xfer(1, `FPSG_OFS_CTRL, 3);
    repeat (3) @(posedge sys_clk);
    chk({swd_secure, dbg_mode}, 2'h1);
    $display("test 3 done");
    rst;
    u_prog.modes(0, 0, 0);
    xfer(1, `FPSG_OFS_CMD, `FPSG_CMD_ERASE);
    u_prog.access(1, 0, 1, 6'h03, g, ok);
    xfer(1, `FPSG_OFS_LATCH, `FPSG_KEY);
    levels;
    xfer(1, `FPSG_OFS_CMD, `FPSG_CMD_RESET);
    xfer(0, `FPSG_OFS_STATUS, 0);
    chk(rd[4:0], 5'h13);
    chk(swd_latch_data, `FPSG_KEY);
    xfer(1, `FPSG_OFS_CTRL, 3);
    u_prog.modes(1, 1, 1);
    repeat (3) @(posedge sys_clk);
    chk({dbg_mode, tst_mode}, 2'h0);
    rnd(0, 1);
    $display("test 4 done");
    results;
  end
endmodule // flash_protection_security_gate_tb
bind fpsg_gate fpsg_gate_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .swd_latch_data(swd_latch_data), .swd_secure(swd_secure), .acc_req(acc_req),
  .acc_write(acc_write), .acc_external(acc_external), .acc_done(acc_done),
  .acc_grant(acc_grant), .dbg_mode(dbg_mode), .tst_mode(tst_mode),
  .dbg_entry_req(dbg_entry_req), .jtag_bscan_active(jtag_bscan_active),
  .part_reset_req(part_reset_req));
`default_nettype wire
